// [design/lnbsr_defines.svh]
// Offsets, field positions and timing counts of the status register bank.
// Assumes inclusion by bare name from the package only; the design modules use its macros without including it.
`ifndef LNBSR_DEFINES_SVH
`define LNBSR_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define LNBSR_ADDR_FAULT 8'h00
`define LNBSR_ADDR_TONE 8'h01

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LNBSR_BIT_OVERLOAD 0
`define LNBSR_BIT_VOLT_LOW 2
`define LNBSR_BIT_PULLDOWN 4
`define LNBSR_BIT_OVERHEAT 6
`define LNBSR_BIT_SUPPLY_LOW 7
`define LNBSR_BIT_TONE_PRESENT 0
`define LNBSR_BIT_TONE_BAD 2
`define LNBSR_BIT_LOAD_LOW 4
`define LNBSR_RESET_BYTE 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LNBSR_CLK_NS 10
`define LNBSR_DEGLITCH_NS 1000
`define LNBSR_DEGLITCH_CYC (`LNBSR_DEGLITCH_NS / `LNBSR_CLK_NS)
`define LNBSR_LEVEL_BITS 4

`endif

// [design/lnbsr_pkg.sv]
// Types of the status register bank.
// Assumes lnbsr_defines.svh is reachable on the include path.
package lnbsr_pkg;
    `include "lnbsr_defines.svh"

    typedef logic [7:0] lnbsr_byte_type;
    typedef logic [`LNBSR_LEVEL_BITS-1:0] lnbsr_level_type;
endpackage

// [design/lnbsr_deglitch_if.sv]
// Interface between the bank and its pull-down deglitch filter.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
interface lnbsr_deglitch_if;
    logic raw;
    logic filtered;
    modport bank (output raw, input filtered);
    modport filter (input raw, output filtered);
endinterface

// [design/lnbsr_deglitch.sv]
// Persistence filter: output rises only after input held past the deglitch period.
// Assumes a synchronised input on the same clock.
`timescale 1ns/100ps
module lnbsr_deglitch (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Filter link
    lnbsr_deglitch_if.filter dg
);
    import lnbsr_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic hit;
    } lnbsr_dg_state_type;

    lnbsr_dg_state_type state, next_state;

    always_comb begin
        next_state = state;
        if (!dg.raw) begin
            next_state.count = 16'h0000;
            next_state.hit = 1'b0;
        end else if (state.count >= 16'(`LNBSR_DEGLITCH_CYC)) begin
            next_state.hit = 1'b1;
        end else begin
            next_state.count = state.count + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign dg.filtered = state.hit;
endmodule

// [design/lnbsr_bank.sv]
// Read-only diagnostic status bank with output recovery control.
// Assumes an external bus engine presents address, read and write strobes.
// Condition inputs come from analogue detectors and are asynchronous.
//
// Notes on behaviour
// - Both status registers ignore bus writes.
// - Fault status register decodes at address zero.
// - Tone and current status at address one.
// - Fault bit 0 shows output overload.
// - Fault bit 2 shows output voltage low.
// - Fault bit 4 after persistent pull-down overcurrent.
// - Fault bit 6 set above 150 C.
// - Overheat clears only below 135 C.
// - Fault bit 7 shows input supply low.
// - Tone bit 0 shows tone detected.
// - Tone bit 2 shows tone out of spec.
// - Tone bit 4 shows load current low.
// - Overload recovery clears level select, disables output.
// - Auto recovery restores previous level after overheat.
`timescale 1ns/100ps
module lnbsr_bank (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register access
    input wire lnbsr_pkg::lnbsr_byte_type addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire lnbsr_pkg::lnbsr_byte_type wdata_i,
    output lnbsr_pkg::lnbsr_byte_type rdata_o,
    output logic rvalid_o,
    // Detector conditions
    input wire logic overload_i,
    input wire logic volt_low_i,
    input wire logic pulldown_oc_i,
    input wire logic temp_above_150_i,
    input wire logic temp_below_135_i,
    input wire logic supply_low_i,
    input wire logic tone_detect_input,
    input wire logic tone_bad_i,
    input wire logic load_low_i,
    // Output control
    input wire lnbsr_pkg::lnbsr_level_type level_wr_data_i,
    input wire logic level_wr_i,
    input wire logic overload_recovery_select_i,
    input wire logic overheat_recovery_select_i,
    output lnbsr_pkg::lnbsr_level_type output_level_select_o,
    output logic output_enable_o
);
    import lnbsr_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [8:0] sync1;
        logic [8:0] sync2;
        logic overheat;
        lnbsr_byte_type rdata;
        logic rvalid;
        lnbsr_level_type level;
        logic out_en;
    } lnbsr_state_type;

    lnbsr_state_type state, next_state;
    lnbsr_deglitch_if dg();
    lnbsr_byte_type fault_byte, tone_byte;

    lnbsr_deglitch u_deglitch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .dg(dg.filter)
    );

    assign dg.raw = state.sync2[2];

    // ----------------------------------------------------------------
    // Status bytes
    // ----------------------------------------------------------------
    always_comb begin
        fault_byte = `LNBSR_RESET_BYTE;
        fault_byte[`LNBSR_BIT_OVERLOAD] = state.sync2[0];
        fault_byte[`LNBSR_BIT_VOLT_LOW] = state.sync2[1];
        fault_byte[`LNBSR_BIT_PULLDOWN] = dg.filtered;
        fault_byte[`LNBSR_BIT_OVERHEAT] = state.overheat;
        fault_byte[`LNBSR_BIT_SUPPLY_LOW] = state.sync2[5];
        tone_byte = `LNBSR_RESET_BYTE;
        tone_byte[`LNBSR_BIT_TONE_PRESENT] = state.sync2[6];
        tone_byte[`LNBSR_BIT_TONE_BAD] = state.sync2[7];
        tone_byte[`LNBSR_BIT_LOAD_LOW] = state.sync2[8];
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.sync1 = {load_low_i, tone_bad_i, tone_detect_input, supply_low_i,
                            temp_below_135_i, temp_above_150_i, pulldown_oc_i,
                            volt_low_i, overload_i};
        next_state.sync2 = state.sync1;
        // Hysteresis: hold between thresholds so the flag does not chatter.
        if (state.sync2[3]) begin
            next_state.overheat = 1'b1;
        end else if (state.sync2[4]) begin
            next_state.overheat = 1'b0;
        end
        // Data is captured on the read strobe itself, so it reflects that moment.
        next_state.rvalid = rd_i;
        if (rd_i) begin
            unique case (addr_i)
                `LNBSR_ADDR_FAULT: next_state.rdata = fault_byte;
                `LNBSR_ADDR_TONE: next_state.rdata = tone_byte;
                default: next_state.rdata = `LNBSR_RESET_BYTE;
            endcase
        end
        // Writes to the status addresses fall through with no effect.
        // A write that coincides with a read must not cancel the read capture.
        if (wr_i && !rd_i && (addr_i == `LNBSR_ADDR_FAULT || addr_i == `LNBSR_ADDR_TONE)) begin
            next_state.rdata = state.rdata;
        end
        if (level_wr_i) begin
            next_state.level = level_wr_data_i;
        end
        next_state.out_en = 1'b1;
        if (state.sync2[0]) begin
            next_state.out_en = 1'b0;
            if (overload_recovery_select_i) begin
                next_state.level = '0;
            end
        end
        if (state.overheat) begin
            next_state.out_en = 1'b0;
            if (overheat_recovery_select_i) begin
                next_state.level = '0;
            end
        end
        // With recovery select clear the level is kept, so output returns on its own.
        if (!state.overheat && !state.sync2[0]) begin
            next_state.out_en = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rdata_o = state.rdata;
    assign rvalid_o = state.rvalid;
    assign output_level_select_o = state.level;
    assign output_enable_o = state.out_en;

    wire unused_wdata = ^wdata_i;
endmodule

// [verification/lnbsr_chk.sv]
// Port checker of the status bank.
// Assumes a bind onto lnbsr_bank; one clock, reset active high.
`timescale 1ns/100ps
module lnbsr_chk (
    // Bank ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire lnbsr_pkg::lnbsr_byte_type addr_i,
    input wire logic rd_i,
    input wire lnbsr_pkg::lnbsr_byte_type rdata_o,
    input wire logic rvalid_o,
    input wire logic overload_i,
    input wire logic supply_low_i,
    input wire logic pulldown_oc_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_rd0; rd_i && addr_i == 8'h00; endsequence
    sequence s_rd1; rd_i && addr_i == 8'h01; endsequence
    property p_ans; rd_i |=> rvalid_o; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_idle; !rd_i |=> !rvalid_o && $stable(rdata_o); endproperty
    a_idle: assert property (p_idle) else $error("data moved without read");
    property p_res0; s_rd0 |=> (rdata_o & 8'h2a) == 8'h00; endproperty
    a_res0: assert property (p_res0) else $error("spare fault bit set");
    property p_res1; s_rd1 |=> (rdata_o & 8'hea) == 8'h00; endproperty
    a_res1: assert property (p_res1) else $error("spare tone bit set");
    property p_unm; rd_i && addr_i > 8'h01 |=> rdata_o == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    // Inputs pass two flops, so only a level held for three edges is judged.
    property p_ovl; s_rd0 ##0 ($stable(overload_i) && $past(overload_i, 2) == overload_i
        && !$past(rst_i, 3)) |=> rdata_o[0] == $past(overload_i); endproperty
    a_ovl: assert property (p_ovl) else $error("overload bit wrong");
    property p_sup; s_rd0 ##0 ($stable(supply_low_i) && $past(supply_low_i, 2) == supply_low_i
        && !$past(rst_i, 3)) |=> rdata_o[7] == $past(supply_low_i); endproperty
    a_sup: assert property (p_sup) else $error("supply bit wrong");
    property p_pd; s_rd0 ##0 !$past(pulldown_oc_i, 50) |=> !rdata_o[4]; endproperty
    a_pd: assert property (p_pd) else $error("pull-down bit too early");
endmodule

// [verification/lnbsr_host.sv]
// Host model: one register access at a time on the bank's strobes.
// Assumes the bank samples its strobes on the rising clock edge.
`timescale 1ns/100ps
module lnbsr_host (
    // Bus
    input wire logic clk_i,
    output lnbsr_pkg::lnbsr_byte_type addr_o,
    output logic rd_o,
    output logic wr_o,
    output lnbsr_pkg::lnbsr_byte_type wdata_o
);
    import lnbsr_pkg::*;
    initial {addr_o, rd_o, wr_o, wdata_o} = '0;
    task automatic access(input lnbsr_byte_type a, input logic w, input lnbsr_byte_type d);
        @(posedge clk_i);
        #1 {addr_o, rd_o, wr_o, wdata_o} = {a, !w, w, d};
        @(posedge clk_i);
        // Released address and data flip and both strobes drop so a stale value never looks valid.
        #1 {addr_o, rd_o, wr_o, wdata_o} = {~a, 2'b00, ~d};
    endtask
endmodule

// [verification/lnbsr_bank_tb_top.sv]
// Bench of the status bank driven through the host model.
// Assumes the package, design, checker and host files compile first.
`timescale 1ns/100ps
module lnbsr_bank_tb_top;
    import lnbsr_pkg::*;
    logic clk_i = 0, rst_i = 1, lwr = 0, orsel = 0, hsel = 0, ot = 0, en, rd_i, wr_i, rvalid_o;
    logic [8:0] c = '0;
    lnbsr_level_type lvl = '0, lv;
    lnbsr_byte_type addr_i, wdata_i, rdata_o, q[$];
    int n_errors = 0, total_checks = 0, seed = 42334;
    always #5 clk_i = ~clk_i;
    lnbsr_host lnbsr_host_i (.clk_i, .addr_o(addr_i), .rd_o(rd_i), .wr_o(wr_i), .wdata_o(wdata_i));
    lnbsr_bank lnbsr_bank_i (.clk_i, .rst_i, .addr_i, .rd_i, .wr_i, .wdata_i, .rdata_o,
        .rvalid_o, .overload_i(c[0]), .volt_low_i(c[1]), .pulldown_oc_i(c[2]),
        .temp_above_150_i(c[3]), .temp_below_135_i(c[4]), .supply_low_i(c[5]),
        .tone_detect_input(c[6]), .tone_bad_i(c[7]), .load_low_i(c[8]),
        .level_wr_data_i(lvl), .level_wr_i(lwr), .overload_recovery_select_i(orsel),
        .overheat_recovery_select_i(hsel), .output_level_select_o(lv), .output_enable_o(en));
    task automatic chk(input string n, input lnbsr_byte_type x, input lnbsr_byte_type g);
        total_checks++;
        if (g !== x) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic rx(input lnbsr_byte_type a, input lnbsr_byte_type x);
        q.push_back(x);
        lnbsr_host_i.access(a, 1'b0, 8'h00);
    endtask
    task automatic hold(input logic [8:0] v, input int n);
        c = v;
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Sampled mid-cycle so the registered answer has settled.
    always @(negedge clk_i) begin
        if (rvalid_o === 1'b1) chk("rdata", q.pop_front(), rdata_o);
    end
    initial begin
        repeat (20) @(posedge clk_i);
        #1 rst_i = 0;
        for (int i = 0; i < 20; i++) begin
            hold(9'($random(seed)) & 9'h1fb, 3);
            ot = c[3] ? 1'b1 : (c[4] ? 1'b0 : ot);
            lnbsr_host_i.access(8'(i & 1), 1'b1, 8'($random(seed)));
            rx(8'h00, {c[5], ot, 3'b000, c[1], 1'b0, c[0]});
            rx(8'h01, {3'b000, c[8], 1'b0, c[7], 1'b0, c[6]});
            rx(8'h02 + 8'(i), 8'h00);
        end
        hold(9'h014, 60);
        rx(8'h00, 8'h00);
        hold(9'h014, 70);
        rx(8'h00, 8'h10);
        orsel = 1;
        hold(9'h010, 1);
        {lvl, lwr} = {4'h9, 1'b1};
        hold(9'h011, 1);
        lwr = 0;
        hold(9'h011, 6);
        chk("enable", 8'h00, {7'h00, en});
        hold(9'h010, 6);
        chk("level", 8'h00, {4'h0, lv});
        orsel = 0;
        {lvl, lwr} = {4'h6, 1'b1};
        hold(9'h008, 1);
        lwr = 0;
        hold(9'h008, 6);
        chk("enable", 8'h00, {7'h00, en});
        hold(9'h000, 3);
        rx(8'h00, 8'h40);
        hold(9'h010, 6);
        chk("level", 8'h06, {4'h0, lv});
        chk("enable", 8'h01, {7'h00, en});
        // With the overheat recovery select high the level is not kept.
        hsel = 1;
        hold(9'h008, 6);
        chk("level", 8'h00, {4'h0, lv});
        hold(9'h010, 6);
        chk("enable", 8'h01, {7'h00, en});
        hsel = 0;
        chk("pending", 8'h00, 8'(q.size()));
        tally_and_finish();
    end
    initial begin
        #60000;
        n_errors++;
        tally_and_finish();
    end
endmodule
bind lnbsr_bank lnbsr_chk lnbsr_chk_i (.clk_i, .rst_i, .addr_i, .rd_i, .rdata_o, .rvalid_o,
    .overload_i, .supply_low_i, .pulldown_oc_i);
